// ---- verilog/srwe_top.sv ----
// Soft reset register and wake event logic
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
// Operation
// - Writing one to bit 6 puts the fieldbus core into reset.
// - Core reset bit clears itself on core release; zero after power-up.
// - Writes to a self-clearing reset bit are ignored while it is one.
// - Bit 2 resets the second PHY, held at least 102 us.
// - Bit 1 resets the first PHY, held at least 102 us.
// - Each PHY reset bit clears itself when its PHY is released.
// - Bit 0 resets the whole chip except PLL and both PHYs.
// - Digital reset returns CSRs to defaults except surviving bits.
// - Digital reset bit clears itself once the chip is released.
// - Reset register readable in any state; partial reads allowed.
// - Energy on cable ends power-down and sets the energy-on flag.
// - Carrier already present at power-down enable reports detection at once.
// - A PHY interrupt is raised only for sources unmasked.
// - PHY interrupts appear in status bits 26 and 27, drive the pin.
// - Any PHY interrupt sets that port's wake status bit.
// - Enabled wake-on-LAN events set the wake source flag.
// - Per-port wake status bits stay latched after the cause goes.
// - Latched wake bits ANDed with enables, ORed into event status.
// - Event status sets whatever its interrupt enable is.
// - Event status gated by its enable, ORed onto interrupt output.
// - With auto wake set, an event wakes the system from low power.
// - Clock disable freezes without reset; block never self-resets on it.
module srwe_top #(
    parameter int PHY_HOLD = srwe_pkg::PHY_HOLD_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [1:0] i_phy_energy,
    input wire logic [1:0] i_phy_wol_evt,
    input wire logic i_low_power,
    output logic [31:0] o_rdata,
    output logic o_core_rst,
    output logic [1:0] o_phy_rst,
    output logic o_dig_rst,
    output logic [1:0] o_phy_pwrdn,
    output logic o_irq,
    output logic o_wake
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [31:0] rdata;
        logic [3:0] rst_bits;
        logic [3:0][13:0] cnt;
        logic [1:0] en1;
        logic [1:0] en2;
        logic [1:0] wl1;
        logic [1:0] wl2;
        logic [1:0] wl3;
        logic [1:0] edpd_en;
        logic [1:0] edpd_d;
        logic [1:0] pd;
        logic [1:0] wol_en;
        logic [1:0][1:0] src;
        logic [1:0][1:0] mask;
        logic [1:0] wsts;
        logic [1:0] wen;
        logic auto_wake;
        logic pes;
        logic [2:0] int_en;
        logic irq;
        logic wake;
    } srwe_state_t;

    srwe_state_t q_ff;
    srwe_state_t nxt_q;

    localparam logic [13:0] PHY_HOLD_W = PHY_HOLD[13:0];

    // Hold length of each reset channel
    function automatic logic [13:0] hold_of(input int ch);
        logic [13:0] v;
        v = srwe_pkg::DIG_HOLD_CYC;
        if (ch == srwe_pkg::CH_PHY_A || ch == srwe_pkg::CH_PHY_B) begin
            v = PHY_HOLD_W;
        end else if (ch == srwe_pkg::CH_CORE) begin
            v = srwe_pkg::CORE_HOLD_CYC;
        end
        return v;
    endfunction

    // Position of each reset channel in the soft reset register
    function automatic int bit_of(input int ch);
        int b;
        b = srwe_pkg::BIT_DIG_RST;
        case (ch)
            srwe_pkg::CH_PHY_A: b = srwe_pkg::BIT_FIRST_PORT_PHY_RESET_BIT;
            srwe_pkg::CH_PHY_B: b = srwe_pkg::BIT_SECOND_PORT_PHY_RESET_BIT;
            srwe_pkg::CH_CORE: b = srwe_pkg::BIT_CORE_RST;
            default: b = srwe_pkg::BIT_DIG_RST;
        endcase
        return b;
    endfunction

    logic [1:0] phy_int;
    logic pme_evt;

    always_comb begin
        nxt_q = q_ff;
        phy_int = 2'h0;
        pme_evt = 1'b0;
        nxt_q.rdata = 32'h0000_0000;
        // ------------------------------------------------------------
        // Input synchronisers
        // ------------------------------------------------------------
        nxt_q.en1 = i_phy_energy;
        nxt_q.en2 = q_ff.en1;
        nxt_q.wl1 = i_phy_wol_evt;
        nxt_q.wl2 = q_ff.wl1;
        nxt_q.wl3 = q_ff.wl2;
        nxt_q.edpd_d = q_ff.edpd_en;
        // ------------------------------------------------------------
        // Register reads
        // ------------------------------------------------------------
        // read path always live
        if (i_rd) begin
            case (i_addr)
                srwe_pkg::ADDR_SOFT_RST: begin
                    for (int c = 0; c < 4; c++) begin
                        nxt_q.rdata[bit_of(c)] = q_ff.rst_bits[c];
                    end
                end
                srwe_pkg::ADDR_PMC: begin
                    nxt_q.rdata[srwe_pkg::PMC_EDPD_LSB +: 2] = q_ff.edpd_en;
                    nxt_q.rdata[srwe_pkg::PMC_PD_LSB +: 2] = q_ff.pd;
                    nxt_q.rdata[srwe_pkg::PMC_WOL_EN_LSB +: 2] = q_ff.wol_en;
                    nxt_q.rdata[srwe_pkg::PMC_WEN_LSB +: 2] = q_ff.wen;
                    nxt_q.rdata[srwe_pkg::PMC_WSTS_LSB +: 2] = q_ff.wsts;
                    nxt_q.rdata[srwe_pkg::PMC_AUTO_WAKE] = q_ff.auto_wake;
                end
                srwe_pkg::ADDR_INTERRUPT_STATUS: begin
                    nxt_q.rdata[srwe_pkg::INT_PHY_LSB] = |(q_ff.src[0] & q_ff.mask[0]);
                    nxt_q.rdata[srwe_pkg::INT_PHY_LSB + 1] = |(q_ff.src[1] & q_ff.mask[1]);
                    nxt_q.rdata[srwe_pkg::INT_PME] = q_ff.pes;
                end
                srwe_pkg::ADDR_INT_EN: begin
                    nxt_q.rdata[srwe_pkg::INT_PHY_LSB +: 2] = q_ff.int_en[1:0];
                    nxt_q.rdata[srwe_pkg::INT_PME] = q_ff.int_en[2];
                end
                srwe_pkg::ADDR_SRC_A: nxt_q.rdata[1:0] = q_ff.src[0];
                srwe_pkg::ADDR_SRC_B: nxt_q.rdata[1:0] = q_ff.src[1];
                srwe_pkg::ADDR_MASK_A: nxt_q.rdata[1:0] = q_ff.mask[0];
                srwe_pkg::ADDR_MASK_B: nxt_q.rdata[1:0] = q_ff.mask[1];
                default: nxt_q.rdata = 32'h0000_0000;
            endcase
        end
        // ------------------------------------------------------------
        // Reset channels
        // ------------------------------------------------------------
        for (int c = 0; c < 4; c++) begin
            // PHY bit clears on PHY release
            // digital bit clears on chip release
            if (q_ff.cnt[c] != 14'h0000) begin
                nxt_q.cnt[c] = q_ff.cnt[c] - 14'h0001;
                if (q_ff.cnt[c] == 14'h0001) begin
                    nxt_q.rst_bits[c] = 1'b0;
                end
            end
            if (i_wr && i_addr == srwe_pkg::ADDR_SOFT_RST && !q_ff.rst_bits[c]
                && i_wdata[bit_of(c)]) begin
                nxt_q.rst_bits[c] = 1'b1;
                nxt_q.cnt[c] = hold_of(c);
            end
        end
        // ------------------------------------------------------------
        // Other register writes, clears before hardware sets
        // ------------------------------------------------------------
        if (i_wr && !q_ff.rst_bits[srwe_pkg::CH_DIG]) begin
            case (i_addr)
                srwe_pkg::ADDR_PMC: begin
                    nxt_q.edpd_en = i_wdata[srwe_pkg::PMC_EDPD_LSB +: 2];
                    nxt_q.wol_en = i_wdata[srwe_pkg::PMC_WOL_EN_LSB +: 2];
                    nxt_q.wen = i_wdata[srwe_pkg::PMC_WEN_LSB +: 2];
                    nxt_q.wsts = q_ff.wsts & ~i_wdata[srwe_pkg::PMC_WSTS_LSB +: 2];
                    nxt_q.auto_wake = i_wdata[srwe_pkg::PMC_AUTO_WAKE];
                end
                srwe_pkg::ADDR_INTERRUPT_STATUS: begin
                    nxt_q.pes = q_ff.pes & ~i_wdata[srwe_pkg::INT_PME];
                end
                srwe_pkg::ADDR_INT_EN: begin
                    nxt_q.int_en[1:0] = i_wdata[srwe_pkg::INT_PHY_LSB +: 2];
                    nxt_q.int_en[2] = i_wdata[srwe_pkg::INT_PME];
                end
                srwe_pkg::ADDR_SRC_A: nxt_q.src[0] = q_ff.src[0] & ~i_wdata[1:0];
                srwe_pkg::ADDR_SRC_B: nxt_q.src[1] = q_ff.src[1] & ~i_wdata[1:0];
                srwe_pkg::ADDR_MASK_A: nxt_q.mask[0] = i_wdata[1:0];
                srwe_pkg::ADDR_MASK_B: nxt_q.mask[1] = i_wdata[1:0];
                default: nxt_q.pes = nxt_q.pes;
            endcase
        end
        // ------------------------------------------------------------
        // Per-port energy detect and wake-on-LAN
        // ------------------------------------------------------------
        for (int p = 0; p < 2; p++) begin
            if (q_ff.edpd_en[p] && !q_ff.en2[p]) begin
                nxt_q.pd[p] = 1'b1;
            end
            if (!q_ff.edpd_en[p]) begin
                nxt_q.pd[p] = 1'b0;
            end
            // carrier at enable detects at once
            if (q_ff.edpd_en[p] && q_ff.en2[p] && (q_ff.pd[p] || !q_ff.edpd_d[p])) begin
                nxt_q.pd[p] = 1'b0;
                nxt_q.src[p][srwe_pkg::SRC_ENERGY] = 1'b1;
            end
            if (q_ff.wol_en[p] && q_ff.wl2[p] && !q_ff.wl3[p]) begin
                nxt_q.src[p][srwe_pkg::SRC_WOL] = 1'b1;
            end
            phy_int[p] = |(q_ff.src[p] & q_ff.mask[p]);
            if (phy_int[p]) begin
                nxt_q.wsts[p] = 1'b1;
            end
        end
        pme_evt = |(q_ff.wsts & q_ff.wen);
        if (pme_evt) begin
            nxt_q.pes = 1'b1;
        end
        nxt_q.irq = |({q_ff.pes, phy_int} & q_ff.int_en);
        nxt_q.wake = pme_evt && q_ff.auto_wake && i_low_power;
        // ------------------------------------------------------------
        // Digital reset of the CSRs, wake status survives
        // ------------------------------------------------------------
        // defaults except surviving bits
        if (q_ff.rst_bits[srwe_pkg::CH_DIG]) begin
            nxt_q.edpd_en = 2'h0;
            nxt_q.pd = 2'h0;
            nxt_q.wol_en = 2'h0;
            nxt_q.wen = 2'h0;
            nxt_q.auto_wake = 1'b0;
            nxt_q.pes = 1'b0;
            nxt_q.int_en = 3'h0;
            nxt_q.src = '0;
            nxt_q.mask = '0;
            nxt_q.irq = 1'b0;
            nxt_q.wake = 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign o_rdata = q_ff.rdata;
    assign o_core_rst = q_ff.rst_bits[srwe_pkg::CH_CORE];
    assign o_phy_rst = q_ff.rst_bits[srwe_pkg::CH_PHY_B:srwe_pkg::CH_PHY_A];
    assign o_dig_rst = q_ff.rst_bits[srwe_pkg::CH_DIG];
    assign o_phy_pwrdn = q_ff.pd;
    assign o_irq = q_ff.irq;
    assign o_wake = q_ff.wake;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    logic [13:0] phya_len_ff;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            phya_len_ff <= 14'h0000;
        end else if (o_phy_rst[0]) begin
            phya_len_ff <= phya_len_ff + 14'h0001;
        end else begin
            phya_len_ff <= 14'h0000;
        end
    end

    logic [13:0] phyb_len_ff;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            phyb_len_ff <= 14'h0000;
        end else if (o_phy_rst[1]) begin
            phyb_len_ff <= phyb_len_ff + 14'h0001;
        end else begin
            phyb_len_ff <= 14'h0000;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_core_rst_set: assert property (i_wr && i_addr == srwe_pkg::ADDR_SOFT_RST
        && i_wdata[srwe_pkg::BIT_CORE_RST] && !o_core_rst |=> o_core_rst)
        else $error("core reset not started");
    a_core_self_clr: assert property ($rose(o_core_rst) |-> ##[15:17] !o_core_rst)
        else $error("core reset bit did not self clear");
    a_wr_ignored: assert property (o_phy_rst[1] && $past(o_phy_rst[1])
        |-> q_ff.cnt[srwe_pkg::CH_PHY_B] == $past(q_ff.cnt[srwe_pkg::CH_PHY_B]) - 14'h0001)
        else $error("write restarted a running reset");
    a_phyb_hold: assert property ($rose(o_phy_rst[1]) |-> o_phy_rst[1] [*8])
        else $error("second PHY reset too short");
    a_phya_hold: assert property ($fell(o_phy_rst[0])
        |-> $past(phya_len_ff) >= PHY_HOLD_W - 14'h0001)
        else $error("first PHY reset shorter than hold");
    a_phyb_len: assert property ($fell(o_phy_rst[1])
        |-> $past(phyb_len_ff) >= PHY_HOLD_W - 14'h0001)
        else $error("second PHY reset shorter than hold");
    a_dig_clr: assert property ($rose(o_dig_rst) |-> ##[15:17] !o_dig_rst)
        else $error("digital reset bit did not self clear");
    a_dig_defaults: assert property (o_dig_rst |=> !o_irq && q_ff.int_en == 3'h0)
        else $error("CSR not defaulted during digital reset");
    a_wsts_latch: assert property (q_ff.wsts[0]
        && !(i_wr && i_addr == srwe_pkg::ADDR_PMC) |=> q_ff.wsts[0])
        else $error("wake status dropped without clear");
    a_pes_set: assert property (|(q_ff.wsts & q_ff.wen) && !o_dig_rst |=> q_ff.pes)
        else $error("event status not set");
    a_irq_gate: assert property (q_ff.pes && q_ff.int_en[2] && !o_dig_rst |=> o_irq)
        else $error("interrupt output not raised");
    a_wake_req: assert property (o_wake |-> $past(q_ff.auto_wake) && $past(i_low_power))
        else $error("wake without enable");

    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000)
        else $error("read data outside its cycle");
    a_energy_on: assert property (q_ff.edpd_en[0] && q_ff.pd[0] && q_ff.en2[0]
        && !o_dig_rst |=> q_ff.src[0][srwe_pkg::SRC_ENERGY] && !o_phy_pwrdn[0])
        else $error("energy did not end power-down");
    a_phy_irq: assert property (|(q_ff.src[0] & q_ff.mask[0]) && q_ff.int_en[0]
        && !o_dig_rst |=> o_irq)
        else $error("first PHY interrupt not on pin");

    c_phy_reset: cover property ($fell(o_phy_rst[0]));
    c_wake: cover property (o_wake);
    c_irq_pme: cover property (o_irq && q_ff.pes);
    c_dig_reset: cover property ($fell(o_dig_rst));
endmodule

// ---- verilog/srwe_pkg.sv ----
// Constants and register map of the soft reset and wake event block
package srwe_pkg;
    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [11:0] ADDR_SOFT_RST = 12'h1F8;
    localparam logic [11:0] ADDR_PMC = 12'h084;
    localparam logic [11:0] ADDR_INTERRUPT_STATUS = 12'h058;
    localparam logic [11:0] ADDR_INT_EN = 12'h05C;
    localparam logic [11:0] ADDR_SRC_A = 12'h120;
    localparam logic [11:0] ADDR_SRC_B = 12'h124;
    localparam logic [11:0] ADDR_MASK_A = 12'h128;
    localparam logic [11:0] ADDR_MASK_B = 12'h12C;
    // ----------------------------------------------------------------
    // Soft reset control bits
    // ----------------------------------------------------------------
    localparam int BIT_DIG_RST = 0;
    localparam int BIT_FIRST_PORT_PHY_RESET_BIT = 1;
    localparam int BIT_SECOND_PORT_PHY_RESET_BIT = 2;
    localparam int BIT_CORE_RST = 6;
    // Internal index of each reset channel
    localparam int CH_DIG = 0;
    localparam int CH_PHY_A = 1;
    localparam int CH_PHY_B = 2;
    localparam int CH_CORE = 3;
    // ----------------------------------------------------------------
    // Power management control fields
    // ----------------------------------------------------------------
    localparam int PMC_EDPD_LSB = 0;
    localparam int PMC_PD_LSB = 2;
    localparam int PMC_WOL_EN_LSB = 4;
    localparam int PMC_WEN_LSB = 14;
    localparam int PMC_WSTS_LSB = 16;
    localparam int PMC_AUTO_WAKE = 28;
    // ----------------------------------------------------------------
    // Interrupt status and enable fields
    // ----------------------------------------------------------------
    localparam int INT_PME = 17;
    localparam int INT_PHY_LSB = 26;
    // PHY source flag and mask fields
    localparam int SRC_ENERGY = 0;
    localparam int SRC_WOL = 1;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int PHY_HOLD_NS = 102000;
    localparam int PHY_HOLD_CYC = (PHY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [13:0] DIG_HOLD_CYC = 14'h0010;
    localparam logic [13:0] CORE_HOLD_CYC = 14'h0010;
    localparam int CNT_W = 14;
endpackage

// ---- dv/srwe_top_tb.sv ----
// Self-checking testbench of the soft reset and wake event block
`timescale 1ns/10ps
module srwe_top_tb;
    localparam int HOLD = srwe_pkg::PHY_HOLD_CYC;
    logic i_clk;
    logic i_rst;
    logic [11:0] i_addr;
    logic [31:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [1:0] i_phy_energy;
    logic [1:0] i_phy_wol_evt;
    logic i_low_power;
    logic [31:0] o_rdata;
    logic o_core_rst;
    logic [1:0] o_phy_rst;
    logic o_dig_rst;
    logic [1:0] o_phy_pwrdn;
    logic o_irq;
    logic o_wake;
    int fail_count = 0;
    int tests_run = 0;
    logic [31:0] seed = 32'h0000_9D34;
    logic [31:0] d;
    logic [31:0] cfg;

    srwe_top #(.PHY_HOLD(HOLD)) i_srwe_top (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_phy_energy(i_phy_energy),
        .i_phy_wol_evt(i_phy_wol_evt), .i_low_power(i_low_power), .o_rdata(o_rdata),
        .o_core_rst(o_core_rst), .o_phy_rst(o_phy_rst), .o_dig_rst(o_dig_rst),
        .o_phy_pwrdn(o_phy_pwrdn), .o_irq(o_irq), .o_wake(o_wake));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic seen_rst(input int b);
        case (b)
            0: return o_dig_rst;
            1: return o_phy_rst[0];
            2: return o_phy_rst[1];
            default: return o_core_rst;
        endcase
    endfunction

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        v = o_rdata;
    endtask

    // Bounded poll of a register field
    task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] v;
        int n;
        for (n = 0; n < 30; n++) begin
            rd(a, v);
            if ((v & m) === e) break;
        end
        check(v & m, e);
        if (n == 30) summarize();
    endtask

    // Self-clearing reset bit: set, ignored write, timed release
    task automatic pulse_rst(input int b, input int hold);
        logic [31:0] v;
        time t0;
        int n;
        wr(srwe_pkg::ADDR_SOFT_RST, 32'h1 << b);
        t0 = $time;
        #1;
        check(32'(seen_rst(b)), 32'h1);
        wr(srwe_pkg::ADDR_SOFT_RST, 32'h0);
        wr(srwe_pkg::ADDR_SOFT_RST, 32'h1 << b);
        rd(srwe_pkg::ADDR_SOFT_RST, v);
        check(v, 32'h1 << b);
        for (n = 0; n < hold + 50 && seen_rst(b) !== 1'b0; n++) begin
            @(posedge i_clk);
            #1;
        end
        if (n == hold + 50) begin
            check(32'h0, 32'h1);
            summarize();
        end
        n = int'(($time - 1 - t0) / 10);
        check(32'(n), 32'(hold));
        rd(srwe_pkg::ADDR_SOFT_RST, v);
        check(v, 32'h0);
    endtask

    initial begin
        i_rst = 1'b1;
        i_addr = 12'h000;
        i_wdata = 32'h0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_phy_energy = 2'h0;
        i_phy_wol_evt = 2'h0;
        i_low_power = 1'b0;
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(srwe_pkg::ADDR_SOFT_RST, d);
        check(d, 32'h0);
        pulse_rst(1, HOLD);
        pulse_rst(2, HOLD);
        pulse_rst(6, 16);
        // Random mask contents and unmapped accesses
        for (int k = 0; k < 8; k++) begin
            cfg = xorshift();
            wr(srwe_pkg::ADDR_MASK_A, cfg);
            rd(srwe_pkg::ADDR_MASK_A, d);
            check(d, cfg & 32'h3);
            wr(12'h800 | cfg[11:0], ~cfg);
            rd(12'h800 | cfg[11:0], d);
            check(d, 32'h0);
        end
        // Energy detect on the first port
        wr(srwe_pkg::ADDR_MASK_A, 32'h3);
        wr(srwe_pkg::ADDR_INT_EN, 32'h0402_0000);
        cfg = (32'h1 << srwe_pkg::PMC_EDPD_LSB) | (32'h3 << srwe_pkg::PMC_WOL_EN_LSB);
        cfg = cfg | (32'h3 << srwe_pkg::PMC_WEN_LSB) | (32'h1 << srwe_pkg::PMC_AUTO_WAKE);
        wr(srwe_pkg::ADDR_PMC, cfg);
        i_low_power <= 1'b1;
        poll(srwe_pkg::ADDR_PMC, 32'h4, 32'h4);
        @(posedge i_clk);
        i_phy_energy <= 2'h1;
        poll(srwe_pkg::ADDR_SRC_A, 32'h1, 32'h1);
        poll(srwe_pkg::ADDR_INTERRUPT_STATUS, 32'h0402_0000, 32'h0402_0000);
        poll(srwe_pkg::ADDR_PMC, 32'h0003_0004, 32'h0001_0000);
        check(32'({o_irq, o_wake, o_phy_pwrdn[0]}), 32'h6);
        @(posedge i_clk);
        i_phy_energy <= 2'h0;
        repeat (10) @(posedge i_clk);
        wr(srwe_pkg::ADDR_SRC_A, 32'h1);
        poll(srwe_pkg::ADDR_INTERRUPT_STATUS, 32'h0400_0000, 32'h0);
        rd(srwe_pkg::ADDR_PMC, d);
        check(d & 32'h0003_0000, 32'h0001_0000);
        wr(srwe_pkg::ADDR_INT_EN, 32'h0);
        wr(srwe_pkg::ADDR_INTERRUPT_STATUS, 32'h1 << srwe_pkg::INT_PME);
        poll(srwe_pkg::ADDR_INTERRUPT_STATUS, 32'h0002_0000, 32'h0002_0000);
        check(32'(o_irq), 32'h0);
        wr(srwe_pkg::ADDR_PMC, cfg | (32'h1 << srwe_pkg::PMC_WSTS_LSB));
        wr(srwe_pkg::ADDR_INTERRUPT_STATUS, 32'h1 << srwe_pkg::INT_PME);
        poll(srwe_pkg::ADDR_INTERRUPT_STATUS, 32'h1 << srwe_pkg::INT_PME, 32'h0);
        check(32'(o_wake), 32'h0);
        // Wake match on the second port, masked then unmasked
        wr(srwe_pkg::ADDR_MASK_B, 32'h0);
        @(posedge i_clk);
        i_phy_wol_evt <= 2'h2;
        repeat (4) @(posedge i_clk);
        i_phy_wol_evt <= 2'h0;
        poll(srwe_pkg::ADDR_SRC_B, 32'h2, 32'h2);
        rd(srwe_pkg::ADDR_INTERRUPT_STATUS, d);
        check(d & 32'h0800_0000, 32'h0);
        rd(srwe_pkg::ADDR_PMC, d);
        check(d & 32'h0002_0000, 32'h0);
        wr(srwe_pkg::ADDR_MASK_B, 32'h2);
        poll(srwe_pkg::ADDR_INTERRUPT_STATUS, 32'h0802_0000, 32'h0802_0000);
        poll(srwe_pkg::ADDR_PMC, 32'h0002_0000, 32'h0002_0000);
        // Carrier already present when power-down is enabled
        @(posedge i_clk);
        i_phy_energy <= 2'h2;
        repeat (6) @(posedge i_clk);
        wr(srwe_pkg::ADDR_PMC, cfg | 32'h2);
        poll(srwe_pkg::ADDR_SRC_B, 32'h1, 32'h1);
        check(32'(o_phy_pwrdn), 32'h1);
        @(posedge i_clk);
        i_phy_energy <= 2'h0;
        poll(srwe_pkg::ADDR_PMC, 32'h8, 32'h8);
        check(32'(o_phy_pwrdn), 32'h3);
        // Digital reset keeps only the surviving wake status
        pulse_rst(0, 16);
        check(32'(o_phy_rst), 32'h0);
        rd(srwe_pkg::ADDR_PMC, d);
        check(d, 32'h0002_0000);
        rd(srwe_pkg::ADDR_INT_EN, d);
        check(d, 32'h0);
        rd(srwe_pkg::ADDR_MASK_B, d);
        check(d, 32'h0);
        rd(srwe_pkg::ADDR_INTERRUPT_STATUS, d);
        check(d, 32'h0);
        summarize();
    end
endmodule
